// ==== logic/pfd_pkg.sv ====
/*
 * pfd_pkg: constants for the peripheral frame decoder, covering the address ranges,
 * their frames and protection classes, the local identification registers and the
 * state encoding.
 * Assumes a word-addressed (16-bit word) 22-bit CPU data address space.
 */
package pfd_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int AW = 22;  // word address width
  localparam int DW = 32;  // widest data access

  // ----------------------------------------------------------------
  // frame codes and protection classes
  // ----------------------------------------------------------------
  localparam logic [1:0] FRM_NONE = 2'h0;
  localparam logic [1:0] FRM_0    = 2'h1;
  localparam logic [1:0] FRM_1    = 2'h2;
  localparam logic [1:0] FRM_2    = 2'h3;

  localparam logic [1:0] PROT_NO   = 2'h0;  // freely writable
  localparam logic [1:0] PROT_YES  = 2'h1;  // whole block needs unlock
  localparam logic [1:0] PROT_PART = 2'h2;  // per-register, peripheral says which
  localparam logic [1:0] PROT_FLSH = 2'h3;  // unlock plus security unit open

  // ----------------------------------------------------------------
  // special windows
  // ----------------------------------------------------------------
  localparam logic [AW-1:0] EMU_LO     = 22'h000880;
  localparam logic [AW-1:0] EMU_HI     = 22'h000984;
  localparam logic [AW-1:0] PWR_LO     = 22'h000985;
  localparam logic [AW-1:0] PWR_HI     = 22'h000987;
  localparam logic [AW-1:0] FLASH_LO   = 22'h000A80;
  localparam logic [AW-1:0] FLASH_HI   = 22'h000ADF;
  localparam logic [AW-1:0] KEY_LO     = 22'h000AE0;
  localparam logic [AW-1:0] KEY_HI     = 22'h000AEF;
  localparam logic [AW-1:0] A2C_RAM_LO = 22'h001480;
  localparam logic [AW-1:0] A2C_RAM_HI = 22'h0014FF;
  localparam logic [AW-1:0] C2A_RAM_LO = 22'h001500;
  localparam logic [AW-1:0] C2A_RAM_HI = 22'h00157F;
  localparam logic [AW-1:0] NMIWD_LO   = 22'h007060;
  localparam logic [AW-1:0] NMIWD_HI   = 22'h00706F;

  // ----------------------------------------------------------------
  // local registers
  // ----------------------------------------------------------------
  localparam logic [AW-1:0] ADDR_DEVCFG_LO = 22'h000880;
  localparam logic [AW-1:0] ADDR_DEVCFG_HI = 22'h000881;
  localparam logic [AW-1:0] ADDR_CLASS     = 22'h000882;
  localparam logic [AW-1:0] ADDR_REV       = 22'h000883;
  localparam logic [AW-1:0] ADDR_PART      = 22'h3D7E80;
  localparam logic [31:0]   DEVCFG_RST     = 32'h0000_0000;

  // ----------------------------------------------------------------
  // range table: low, high, frame, protection
  // ----------------------------------------------------------------
  localparam int NR = 33;
  localparam logic [AW-1:0] RNG_LO [NR] = '{
    22'h000880, 22'h000985, 22'h000A80, 22'h000AE0, 22'h000B00, 22'h000C00, 22'h000CE0,
    22'h000D00, 22'h001400, 22'h001480, 22'h001500,
    22'h006000, 22'h006400, 22'h006420, 22'h006800, 22'h006840, 22'h006880, 22'h0068C0,
    22'h006900, 22'h006940, 22'h006980, 22'h006A00, 22'h006B00, 22'h006C00, 22'h006F80,
    22'h007010, 22'h007040, 22'h007050, 22'h007060, 22'h007070, 22'h007100, 22'h007900,
    22'h007740};
  localparam logic [AW-1:0] RNG_HI [NR] = '{
    22'h000984, 22'h000987, 22'h000ADF, 22'h000AEF, 22'h000B0F, 22'h000C3F, 22'h000CFF,
    22'h000DFF, 22'h00147F, 22'h0014FF, 22'h00157F,
    22'h0061FF, 22'h00641F, 22'h00643F, 22'h00683F, 22'h00687F, 22'h0068BF, 22'h0068FF,
    22'h00693F, 22'h00697F, 22'h0069BF, 22'h006A1F, 22'h006B3F, 22'h006C7F, 22'h006FFF,
    22'h00702F, 22'h00704F, 22'h00705F, 22'h00706F, 22'h00707F, 22'h00717F, 22'h00793F,
    22'h00774F};
  localparam logic [1:0] RNG_FRM [NR] = '{
    FRM_0, FRM_0, FRM_0, FRM_0, FRM_0, FRM_0, FRM_0, FRM_0, FRM_0, FRM_0, FRM_0,
    FRM_1, FRM_1, FRM_1, FRM_1, FRM_1, FRM_1, FRM_1, FRM_1, FRM_1, FRM_1, FRM_1,
    FRM_1, FRM_1, FRM_1,
    FRM_2, FRM_2, FRM_2, FRM_2, FRM_2, FRM_2, FRM_2, FRM_2};
  localparam logic [1:0] RNG_PROT [NR] = '{
    PROT_YES, PROT_YES, PROT_FLSH, PROT_YES, PROT_NO, PROT_NO, PROT_NO, PROT_NO,
    PROT_YES, PROT_NO, PROT_NO,
    PROT_PART, PROT_PART, PROT_PART, PROT_PART, PROT_PART, PROT_PART, PROT_PART,
    PROT_PART, PROT_PART, PROT_PART, PROT_NO, PROT_PART, PROT_PART, PROT_PART,
    PROT_YES, PROT_NO, PROT_NO, PROT_YES, PROT_YES, PROT_PART, PROT_PART, PROT_NO};

  // ----------------------------------------------------------------
  // access sequencer states, gray along idle-issue-high-done
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_ISSUE = 2'b01,
    ST_HIGH  = 2'b11,
    ST_DONE  = 2'b10
  } pfd_state_t;

endpackage : pfd_pkg

// ==== logic/pfd_frame_decoder.sv ====
/*
 * pfd_frame_decoder: steers master accesses into the three peripheral frames, gates
 * protected writes, filters message-RAM writes and serves the identification registers.
 * Assumes all request inputs come from logic on ref_clk_i and that the addressed
 * peripheral answers part_prot_i and its read data combinationally.
 * Blocked writes still ack, in the same cycles.
 */
// What this block does
// - frame 0 direct, frame 1 32-bit, frame 2 16-bit
// - frame 0 takes 16- and 32-bit accesses
// - protected writes ignored until unlock instruction
// - lock instruction blocks protected writes again
// - main CPU writes to accelerator-out RAM dropped
// - accelerator writes to CPU-out RAM dropped
// - power control block mapped and protected
// - flash registers protected and need security unlocked
// - security key block mapped and protected
// - watchdog interrupt block in frame 2, protected
// - partial blocks gate only selected registers
// - read-only part code, writes ignored
// - emulation block mapped and protected
`timescale 1ns/100ps
module pfd_frame_decoder
  import pfd_pkg::*;
#(
  // id codes
  parameter logic [15:0] CLASS_CODE = 16'h0055,  // arbitrary value
  parameter logic [15:0] REV_CODE   = 16'h0001,  // arbitrary value
  parameter logic [15:0] PART_CODE  = 16'h005A   // arbitrary value
) (
  input  wire logic          ref_clk_i,       // system clock
  input  wire logic          sys_rst_i,       // synchronous reset, active high
  // master side
  input  wire logic          bus_req_i,       // access request, taken when ready
  input  wire logic          bus_accel_i,     // requester is the accelerator
  input  wire logic          bus_wr_i,        // 1 write, 0 read
  input  wire logic          bus_wide_i,      // 32-bit access (even address)
  input  wire logic [AW-1:0] bus_addr_i,      // word address
  input  wire logic [DW-1:0] bus_wdata_i,     // write data, low half for 16-bit
  // gate inputs
  input  wire logic          part_prot_i,     // addressed register needs unlock
  input  wire logic          unlock_instr_i,  // write_unlock_instruction executed
  input  wire logic          lock_instr_i,    // write_lock_instruction executed
  input  wire logic          csu_unlocked_i,  // code_security_unit open
  // frame read data
  input  wire logic [31:0]   f0_rdata_i,      // frame 0 read data
  input  wire logic [31:0]   f1_rdata_i,      // frame 1 read data
  input  wire logic [15:0]   f2_rdata_i,      // frame 2 read data
  // answers to the master
  output logic               bus_ready_o,     // may take a request
  output logic               bus_ack_o,       // access complete, one cycle
  output logic [DW-1:0]      bus_rdata_o,     // read data with ack
  output logic               unlocked_o,      // protected writes allowed
  // frame side, held until next take; a frame 2 wide access steps the address and half-word, selects pulse
  output logic [AW-1:0]      frm_addr_o,      // address to the frames
  output logic [31:0]        frm_wdata_o,     // write data to frames 0 and 1
  output logic               frm_wide_o,      // 32-bit access to frames 0 and 1
  output logic               frm_wr_o,        // write strobe qualifier
  output logic               f0_sel_o,        // frame 0 select, one cycle
  output logic               f1_sel_o,        // frame 1 select, one cycle
  output logic               f2_sel_o,        // frame 2 select, one cycle per half-word
  output logic [15:0]        f2_wdata_o       // frame 2 write half-word
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  // one record: reset and next copy cannot drift
  typedef struct packed {
    // sequencer and answers
    pfd_state_t    st;      // sequencer
    logic          ready;   // idle copy for the port
    logic          ack;     // completion pulse
    logic [31:0]   rdata;   // captured read data
    logic          unlock;  // protection gate open
    logic [31:0]   devcfg;  // device_configuration
    logic [1:0]    frame;   // target frame of the access
    logic          lcl;     // served by local registers
    logic          wr_ok;   // write allowed to land
    logic          rd_ok;   // read allowed to return data
    // held request, kept until next take; the frame 2 high half steps addr and f2_wd, selects pulse
    logic [AW-1:0] addr;
    logic [31:0]   wdata;
    logic          wide;
    logic          wr;
    logic          f0_sel;
    logic          f1_sel;
    logic          f2_sel;
    logic [15:0]   f2_wd;
  } pfd_regs_t;

  // the two copies of the record
  pfd_regs_t s_reg;   // registered state
  pfd_regs_t s_next;  // next state

  // ----------------------------------------------------------------
  // address classification
  // ----------------------------------------------------------------
  // live request verdicts
  logic [1:0] hit_frm;   // frame of the request address
  logic [1:0] hit_prot;  // protection class
  logic       hit_lcl;   // local identification register
  logic       gate_ok;   // protection gate passes a write
  logic       ram_ok;    // message RAM filter passes a write
  logic       csu_ok;    // security unit allows the access

  // range walk; no ranges overlap so the order does not matter
  // a linear walk keeps the table editable
  // a miss leaves frame none: silent finish
  always_comb begin
    hit_frm  = FRM_NONE;
    hit_prot = PROT_NO;
    for (int i = 0; i < NR; i++) begin
      if (bus_addr_i >= RNG_LO[i] && bus_addr_i <= RNG_HI[i]) begin
        hit_frm  = RNG_FRM[i];
        hit_prot = RNG_PROT[i];
      end
    end
    // part code lies outside every frame; id words sit inside the emulation block
    hit_lcl = (bus_addr_i == ADDR_PART) ||
              (bus_addr_i >= ADDR_DEVCFG_LO && bus_addr_i <= ADDR_REV);
  end

  // write and read permission for the incoming request
  // verdicts settle in the take cycle
  // and the sequencer only stores them
  always_comb begin
    case (hit_prot)
      PROT_YES:  gate_ok = s_reg.unlock;
      PROT_PART: gate_ok = s_reg.unlock || !part_prot_i;
      PROT_FLSH: gate_ok = s_reg.unlock && csu_unlocked_i;
      default:   gate_ok = 1'b1;
    endcase
    // flash is unreadable while the security unit is shut
    csu_ok = (hit_prot != PROT_FLSH) || csu_unlocked_i;
    ram_ok = 1'b1;
    if (bus_addr_i >= A2C_RAM_LO && bus_addr_i <= A2C_RAM_HI) begin
      ram_ok = bus_accel_i;
    end else if (bus_addr_i >= C2A_RAM_LO && bus_addr_i <= C2A_RAM_HI) begin
      ram_ok = !bus_accel_i;
    end
  end

  // ----------------------------------------------------------------
  // local register read
  // ----------------------------------------------------------------
  logic [31:0] lcl_rd;  // local read data for the held access

  // a wide read at an even address returns the pair, low word first
  // id words are parameters: writes cannot reach
  // them; only the config word has storage
  always_comb begin
    case (s_reg.addr)
      ADDR_DEVCFG_LO: lcl_rd = s_reg.wide ? s_reg.devcfg : {16'h0000, s_reg.devcfg[15:0]};
      ADDR_DEVCFG_HI: lcl_rd = {16'h0000, s_reg.devcfg[31:16]};
      ADDR_CLASS:     lcl_rd = s_reg.wide ? {REV_CODE, CLASS_CODE} : {16'h0000, CLASS_CODE};
      ADDR_REV:       lcl_rd = {16'h0000, REV_CODE};
      ADDR_PART:      lcl_rd = {16'h0000, PART_CODE};
      default:        lcl_rd = 32'h0000_0000;
    endcase
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  // pulses drop every cycle unless raised
  // below; all else holds by default
  always_comb begin
    s_next        = s_reg;
    s_next.ack    = 1'b0;
    s_next.f0_sel = 1'b0;
    s_next.f1_sel = 1'b0;
    s_next.f2_sel = 1'b0;

    // the gate is a level; the pulses move it
    // lock wins if both instructions land together: the safe side
    if (lock_instr_i) begin
      s_next.unlock = 1'b0;
    end else if (unlock_instr_i) begin
      s_next.unlock = 1'b1;
    end

    // sequencer: idle, issue, high, done
    case (s_reg.st)
      // take a request and launch the first frame cycle
      ST_IDLE: begin
        // ready is high here, so req alone takes
        if (bus_req_i) begin
          s_next.st     = ST_ISSUE;
          s_next.ready  = 1'b0;
          s_next.addr   = bus_addr_i;
          s_next.wdata  = bus_wdata_i;
          s_next.wide   = bus_wide_i;
          s_next.wr     = bus_wr_i;
          s_next.lcl    = hit_lcl;
          s_next.frame  = hit_lcl ? FRM_NONE : hit_frm;
          s_next.wr_ok  = gate_ok && ram_ok && hit_frm != FRM_NONE;
          s_next.rd_ok  = csu_ok;
          // no stale data on a blocked read
          s_next.rdata  = 32'h0000_0000;
          // a blocked write still runs the full sequence, only the strobe is held off
          if (!hit_lcl && (!bus_wr_i || (gate_ok && ram_ok)) && csu_ok) begin
            s_next.f0_sel = hit_frm == FRM_0;
            s_next.f1_sel = hit_frm == FRM_1;
            s_next.f2_sel = hit_frm == FRM_2;
          end
          // frame 2 starts on the low half
          s_next.f2_wd  = bus_wdata_i[15:0];
        end
      end
      // frames answer during the select cycle
      ST_ISSUE: begin
        // narrow reads keep the low half
        case (s_reg.frame)
          FRM_0:   s_next.rdata = s_reg.wide ? f0_rdata_i : {16'h0000, f0_rdata_i[15:0]};
          FRM_1:   s_next.rdata = s_reg.wide ? f1_rdata_i : {16'h0000, f1_rdata_i[15:0]};
          FRM_2:   s_next.rdata = {16'h0000, f2_rdata_i};
          default: s_next.rdata = s_reg.lcl ? lcl_rd : 32'h0000_0000;
        endcase
        // shut security hides flash data
        if (!s_reg.rd_ok) begin
          s_next.rdata = 32'h0000_0000;
        end
        // local writes: only the configuration word is writable, part code ignores them
        // gate verdict as it stood at the take edge
        if (s_reg.lcl && s_reg.wr && s_reg.wr_ok) begin
          if (s_reg.addr == ADDR_DEVCFG_LO) begin
            s_next.devcfg[15:0] = s_reg.wdata[15:0];
            if (s_reg.wide) begin
              s_next.devcfg[31:16] = s_reg.wdata[31:16];
            end
          end else if (s_reg.addr == ADDR_DEVCFG_HI) begin
            s_next.devcfg[31:16] = s_reg.wdata[15:0];
          end
        end
        // the 16-bit frame splits a wide access into two half-word cycles
        if (s_reg.frame == FRM_2 && s_reg.wide) begin
          s_next.st     = ST_HIGH;
          s_next.addr   = s_reg.addr + 22'h000001;
          s_next.f2_wd  = s_reg.wdata[31:16];
          s_next.f2_sel = s_reg.rd_ok && (!s_reg.wr || s_reg.wr_ok);
        end else begin
          s_next.st  = ST_DONE;
          s_next.ack = 1'b1;
        end
      end
      // second half-word of a frame 2 wide access
      // its select was raised on the way in
      ST_HIGH: begin
        s_next.rdata[31:16] = s_reg.rd_ok ? f2_rdata_i : 16'h0000;
        s_next.st  = ST_DONE;
        s_next.ack = 1'b1;
      end
      // one turnaround cycle before the next request
      // keeps back-to-back takes apart
      ST_DONE: begin
        s_next.st    = ST_IDLE;
        s_next.ready = 1'b1;
      end
      // stray codes fall back to idle
      default: begin
        s_next.st    = ST_IDLE;
        s_next.ready = 1'b1;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  // reset shuts the gate and raises ready,
  // so a take may follow at once
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      s_reg        <= '0;
      s_reg.st     <= ST_IDLE;
      s_reg.ready  <= 1'b1;
      s_reg.devcfg <= DEVCFG_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs, all from flops
  // ----------------------------------------------------------------
  // plain copies of flops, no logic after
  assign bus_ready_o = s_reg.ready;
  assign bus_ack_o   = s_reg.ack;
  assign bus_rdata_o = s_reg.rdata;
  assign unlocked_o  = s_reg.unlock;
  assign frm_addr_o  = s_reg.addr;
  assign frm_wdata_o = s_reg.wdata;
  assign frm_wide_o  = s_reg.wide;
  assign frm_wr_o    = s_reg.wr;
  assign f0_sel_o    = s_reg.f0_sel;
  assign f1_sel_o    = s_reg.f1_sel;
  assign f2_sel_o    = s_reg.f2_sel;
  assign f2_wdata_o  = s_reg.f2_wd;

endmodule : pfd_frame_decoder

// ==== verification/pfd_frame_decoder_asserts.sv ====
/* checker for the peripheral frame decoder: gate, routing and timing.
   assumes it sees only the decoder's ports; bound at the foot. */
`timescale 1ns/100ps
module pfd_chk
  import pfd_pkg::*;
(
  input wire logic          ref_clk_i,
  input wire logic          sys_rst_i,
  input wire logic          bus_req_i,
  input wire logic          bus_accel_i,
  input wire logic          part_prot_i,
  input wire logic          unlock_instr_i,
  input wire logic          lock_instr_i,
  input wire logic          csu_unlocked_i,
  input wire logic          bus_ready_o,
  input wire logic          bus_ack_o,
  input wire logic          unlocked_o,
  input wire logic [AW-1:0] frm_addr_o,
  input wire logic          frm_wr_o,
  input wire logic          f0_sel_o,
  input wire logic          f1_sel_o,
  input wire logic          f2_sel_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);
  logic tk, ws, acc_q, unl_q, csu_q, pp_q;  // take, write select, state seen at take
  assign tk = bus_req_i && bus_ready_o;
  assign ws = (f0_sel_o || f1_sel_o || f2_sel_o) && frm_wr_o;
  function automatic logic inr(input logic [AW-1:0] a, lo, hi);
    return (a >= lo) && (a <= hi);
  endfunction
  // gate state is frozen at the take edge, as the decoder uses it
  always_ff @(posedge ref_clk_i) begin
    if (tk) begin
      acc_q <= bus_accel_i;
      unl_q <= unlocked_o;
      csu_q <= csu_unlocked_i;
      pp_q  <= part_prot_i;
    end
  end
  chk_ack_bound: assert property (tk |-> ##[1:4] bus_ack_o)
    else $error("no ack after take");
  chk_ready_drop: assert property (tk |=> !bus_ready_o)
    else $error("ready stayed high after take");
  chk_ack_single: assert property (bus_ack_o |=> bus_ready_o && !bus_ack_o)
    else $error("ack not a single pulse");
  chk_frame_route: assert property ((f0_sel_o || f1_sel_o || f2_sel_o) |->
    (f0_sel_o && frm_addr_o < 22'h006000) || (f1_sel_o && inr(frm_addr_o, 22'h006000,
    22'h006FFF)) || (f2_sel_o && inr(frm_addr_o, 22'h007000, 22'h007FFF)))
    else $error("frame select does not match address");
  chk_prot_gate: assert property (ws && (inr(frm_addr_o, EMU_LO, PWR_HI) ||
    inr(frm_addr_o, KEY_LO, KEY_HI) || inr(frm_addr_o, 22'h001400, 22'h00147F) ||
    inr(frm_addr_o, 22'h007010, 22'h00702F) || inr(frm_addr_o, NMIWD_LO, 22'h00707F))
    |-> unl_q) else $error("protected write passed while locked");
  chk_flash_gate: assert property (ws && inr(frm_addr_o, FLASH_LO, FLASH_HI)
    |-> unl_q && csu_q) else $error("flash write passed a shut gate");
  chk_a2c_drop: assert property (ws && inr(frm_addr_o, A2C_RAM_LO, A2C_RAM_HI) |-> acc_q)
    else $error("cpu write reached accelerator-out ram");
  chk_c2a_drop: assert property (ws && inr(frm_addr_o, C2A_RAM_LO, C2A_RAM_HI) |-> !acc_q)
    else $error("accelerator write reached cpu-out ram");
  chk_part_gate: assert property (ws && f1_sel_o && pp_q &&
    !inr(frm_addr_o, 22'h006A00, 22'h006A1F) |-> unl_q)
    else $error("selected partial register written while locked");
  chk_lock_wins: assert property (lock_instr_i |=> !unlocked_o)
    else $error("gate open after lock");
  chk_unlock_set: assert property (unlock_instr_i && !lock_instr_i |=> unlocked_o)
    else $error("gate shut after unlock");
  cover property (tk && unlocked_o);
  cover property (ws && acc_q);
  cover property (lock_instr_i && unlock_instr_i);
endmodule : pfd_chk
bind pfd_frame_decoder pfd_chk u_chk (.ref_clk_i, .sys_rst_i, .bus_req_i, .bus_accel_i,
  .part_prot_i, .unlock_instr_i, .lock_instr_i, .csu_unlocked_i, .bus_ready_o, .bus_ack_o,
  .unlocked_o, .frm_addr_o, .frm_wr_o, .f0_sel_o, .f1_sel_o, .f2_sel_o);

// ==== verification/pfd_periph_model.sv ====
/* behavioural peripherals behind the three frames.
   assumes selects are one-cycle pulses; odd registers count as protected. */
`timescale 1ns/100ps
module pfd_periph_model
  import pfd_pkg::*;
(
  input  wire logic          ref_clk_i,
  input  wire logic [AW-1:0] bus_addr_i,   // master address, for the partial flag
  input  wire logic [AW-1:0] frm_addr_i,
  input  wire logic [31:0]   frm_wdata_i,
  input  wire logic          frm_wr_i,
  input  wire logic [2:0]    sel_i,        // frame 2, 1, 0 selects
  input  wire logic [15:0]   f2_wdata_i,
  output logic               part_prot_o,
  output logic [31:0]        f0_rd_o,
  output logic [31:0]        f1_rd_o,
  output logic [15:0]        f2_rd_o,
  output int                 wr_cnt_o,     // writes that reached a frame
  output logic [31:0]        last_wd_o
);
  logic [31:0] wp;  // word pair at the frame address
  assign wp = {frm_addr_i[15:0] + 16'h5A3D, frm_addr_i[15:0] ^ 16'h5A3C};
  // unselected frames show the inverse so a stale sample cannot pass
  assign f0_rd_o = sel_i[0] ? wp : ~wp;
  assign f1_rd_o = sel_i[1] ? wp : ~wp;
  assign f2_rd_o = sel_i[2] ? wp[15:0] : ~wp[15:0];
  assign part_prot_o = bus_addr_i[0];
  initial wr_cnt_o = 0;
  always @(posedge ref_clk_i) begin
    if (frm_wr_i && |sel_i) begin
      wr_cnt_o <= wr_cnt_o + 1;
      last_wd_o <= sel_i[2] ? {16'h0000, f2_wdata_i} : frm_wdata_i;
    end
  end
endmodule : pfd_periph_model

// ==== verification/pfd_frame_decoder_tb.sv ====
/* self-checking bench for the peripheral frame decoder.
   assumes the peripheral model and the bound checker. */
`timescale 1ns/100ps
module pfd_frame_decoder_tb import pfd_pkg::*;;
  logic ref_clk_i = 1'b0, sys_rst_i = 1'b1, req = 1'b0, acc = 1'b0, wr = 1'b0, wide = 1'b0;
  logic unl = 1'b0, lck = 1'b0, csu = 1'b0, pp, ready, ack, unl_o, fw, fwr, s0, s1, s2;
  logic [AW-1:0] addr = '0, fa;
  logic [31:0] wdata = '0, rdata, fwd, r0, r1, rd, last_wd;
  logic [15:0] r2, f2w;
  int err_total = 0, checked = 0, lat, dw, wc, n0;
  always #10 ref_clk_i = ~ref_clk_i;
  pfd_frame_decoder #(.CLASS_CODE(16'h1357), .REV_CODE(16'h0246), .PART_CODE(16'h2468))
  DUT (.ref_clk_i, .sys_rst_i, .bus_req_i(req), .bus_accel_i(acc), .bus_wr_i(wr),
    .bus_wide_i(wide), .bus_addr_i(addr), .bus_wdata_i(wdata), .part_prot_i(pp),
    .unlock_instr_i(unl), .lock_instr_i(lck), .csu_unlocked_i(csu), .f0_rdata_i(r0),
    .f1_rdata_i(r1), .f2_rdata_i(r2), .bus_ready_o(ready), .bus_ack_o(ack),
    .bus_rdata_o(rdata), .unlocked_o(unl_o), .frm_addr_o(fa), .frm_wdata_o(fwd),
    .frm_wide_o(fw), .frm_wr_o(fwr), .f0_sel_o(s0), .f1_sel_o(s1), .f2_sel_o(s2),
    .f2_wdata_o(f2w));
  pfd_periph_model u_per (.ref_clk_i, .bus_addr_i(addr), .frm_addr_i(fa), .frm_wdata_i(fwd),
    .frm_wr_i(fwr), .sel_i({s2, s1, s0}), .f2_wdata_i(f2w), .part_prot_o(pp), .f0_rd_o(r0),
    .f1_rd_o(r1), .f2_rd_o(r2), .wr_cnt_o(wc), .last_wd_o(last_wd));
  function automatic logic [31:0] pat(input logic [AW-1:0] a);  // expected word pair
    return {a[15:0] + 16'h5A3D, a[15:0] ^ 16'h5A3C};
  endfunction
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : wrap_up
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp
  // one bus access; records latency, read data and frame writes seen
  task automatic xfer(input logic a, w, wd, input logic [AW-1:0] ad, input logic [31:0] d);
    int c0;
    @(posedge ref_clk_i); #1;
    c0 = wc;
    {req, acc, wr, wide, addr, wdata} = {1'b1, a, w, wd, ad, d};
    @(posedge ref_clk_i); #1;
    req = 1'b0;
    lat = 1;
    while (lat < 8 && ack !== 1'b1) begin
      @(posedge ref_clk_i); #1;
      lat++;
    end
    cmp("ack", 32'h1, {31'h0, ack});
    rd = rdata;
    @(posedge ref_clk_i); #1;
    dw = wc - c0;
  endtask : xfer
  task automatic pulse(input logic u, l);
    @(posedge ref_clk_i); #1;
    {unl, lck} = {u, l};
    @(posedge ref_clk_i); #1;
    {unl, lck} = 2'b00;
    @(posedge ref_clk_i); #1;
  endtask : pulse
  task automatic t_route();
    int n2;
    xfer(0, 0, 0, 22'h000C00, 0); cmp("f0 rd16", pat(22'h000C00) & 32'hFFFF, rd);
    xfer(0, 0, 1, 22'h000C02, 0); cmp("f0 rd32", pat(22'h000C02), rd);
    xfer(0, 1, 1, 22'h000C04, 32'hDEAD_BEEF); cmp("f0 wr32", 32'hDEAD_BEEF, last_wd);
    cmp("frm wide", 32'h1, {31'h0, fw});
    xfer(0, 0, 1, 22'h006800, 0); cmp("f1 rd32", pat(22'h006800), rd);
    xfer(0, 0, 0, 22'h007040, 0); cmp("f2 rd16", pat(22'h007040) & 32'hFFFF, rd);
    n2 = lat;
    xfer(0, 0, 1, 22'h007042, 0);
    cmp("f2 rd32", {pat(22'h007043) << 16} | (pat(22'h007042) & 32'hFFFF), rd);
    cmp("f2 wide lat", n2 + 1, lat);
    xfer(0, 1, 1, 22'h007044, 32'h1234_5678); cmp("f2 halves", 32'h2, dw);
    cmp("f2 high", 32'h1234, last_wd);
  endtask : t_route
  task automatic t_prot();
    logic [AW-1:0] pa [5] = '{22'h000985, 22'h000AE0, 22'h007060, 22'h001400, 22'h000900};
    xfer(0, 1, 0, 22'h000C10, 32'h5); n0 = lat;
    xfer(0, 1, 1, 22'h000880, 32'hFFFF_FFFF); xfer(0, 0, 1, 22'h000880, 0);
    cmp("devcfg locked", 32'h0, rd);
    foreach (pa[i]) begin
      xfer(0, 1, 0, pa[i], 32'h1); cmp("locked wr", 32'h0, dw);
      cmp("blocked lat", n0, lat);
    end
    pulse(1, 0); cmp("unlocked", 32'h1, {31'h0, unl_o});
    xfer(0, 1, 1, 22'h000880, 32'hA5A5_5A5A); xfer(0, 0, 1, 22'h000880, 0);
    cmp("devcfg open", 32'hA5A5_5A5A, rd);
    foreach (pa[i]) begin
      xfer(1, 1, 0, pa[i], 32'h1); cmp("unlocked wr", 32'h1, dw);
    end
    pulse(1, 1); cmp("lock wins", 32'h0, {31'h0, unl_o});
    xfer(0, 1, 0, pa[2], 32'h1); cmp("relocked wr", 32'h0, dw);
  endtask : t_prot
  task automatic t_flash();
    csu = 1'b1;
    xfer(0, 1, 0, 22'h000A80, 32'h1); cmp("flash lock", 32'h0, dw);
    pulse(1, 0);
    csu = 1'b0;
    xfer(0, 1, 0, 22'h000A80, 32'h1); cmp("flash shut wr", 32'h0, dw);
    xfer(0, 0, 0, 22'h000A81, 0); cmp("flash shut rd", 32'h0, rd);
    csu = 1'b1;
    xfer(0, 1, 0, 22'h000ADF, 32'h1); cmp("flash open wr", 32'h1, dw);
    pulse(0, 1);
  endtask : t_flash
  task automatic t_msg_part_ids();
    for (int i = 0; i < 4; i++) begin
      xfer(i[0], 1, 0, i[1] ? 22'h001500 : 22'h001480, 0);
      cmp("msg ram", i[0] ^ i[1], dw);
    end
    xfer(0, 1, 0, 22'h006801, 0); cmp("part prot", 32'h0, dw);
    xfer(0, 1, 0, 22'h006800, 0); cmp("part free", 32'h1, dw);
    xfer(0, 1, 0, 22'h006A01, 0); cmp("capture free", 32'h1, dw);
    xfer(0, 1, 0, 22'h3D7E80, 32'hFFFF); xfer(0, 0, 0, 22'h3D7E80, 0);
    cmp("part code", 32'h2468, rd & 32'hFFFF);
    xfer(0, 0, 0, 22'h000882, 0); cmp("class code", 32'h1357, rd & 32'hFFFF);
    xfer(0, 0, 0, 22'h000883, 0); cmp("rev code", 32'h0246, rd & 32'hFFFF);
    xfer(0, 0, 1, 22'h002000, 0); cmp("unmapped rd", 32'h0, rd);
    xfer(0, 1, 0, 22'h002000, 32'h7); cmp("unmapped wr", 32'h0, dw);
  endtask : t_msg_part_ids
  initial begin
    #400000;
    err_total++;
    wrap_up();
  end
  initial begin
    repeat (10) @(posedge ref_clk_i);
    #1 sys_rst_i = 1'b0;
    cmp("reset ready", 32'h1, {31'h0, ready});
    cmp("reset gate", 32'h0, {31'h0, unl_o});
    t_route();
    t_prot();
    t_flash();
    t_msg_part_ids();
    wrap_up();
  end
endmodule : pfd_frame_decoder_tb
